// [logic/isp_pkg.sv]
package isp_pkg;
    // Operation subcodes; the command port carries isp_op_e codes, not these
    localparam logic [5:0] SUB_SENSE_STATUS = 6'h03;
    localparam logic [5:0] SUB_SENSE_INT = 6'h04;
    localparam logic [5:0] SUB_LOCKOUT = 6'h29;
    localparam logic [5:0] SUB_SET_MASK = 6'h2a;
    localparam logic [5:0] SUB_CLR_MASK = 6'h2b;
    localparam logic [5:0] SUB_PAUSE = 6'h30;

    // Register byte offsets
    localparam logic [11:0] OFS_CMD = 12'h000;
    localparam logic [11:0] OFS_RESULT = 12'h004;
    localparam logic [11:0] OFS_MASK = 12'h008;
    localparam logic [11:0] OFS_STATE = 12'h00c;
    localparam logic [11:0] OFS_FAULT = 12'h010;

    // Reset values
    localparam logic [11:0] MASK_RST = 12'h000;
    localparam logic [7:0] CHAN_PRESENT_DEF = 8'hff;

    // Pause limit
    localparam int PAUSE_LIMIT_MS = 40;
    localparam int CLK_KHZ = 125000;
    localparam int PAUSE_LIMIT_CYC = PAUSE_LIMIT_MS * CLK_KHZ;

    // Command operations
    typedef enum logic [3:0] {
        OP_NONE, OP_SENSE_INT, OP_SENSE_STATUS, OP_COPY_STATUS, OP_PAUSE,
        OP_PRIO_PAUSE, OP_ENABLE, OP_DISABLE, OP_CLEAR_INT, OP_SET_MASK,
        OP_CLR_MASK, OP_LOCKOUT
    } isp_op_e;

    // Result of an operation: next address step
    typedef enum logic [1:0] {
        STEP_NONE, STEP_P1, STEP_P2, STEP_INT
    } isp_step_e;

    // Per-channel condition lines
    typedef struct packed {
        logic [7:0] ext_int;
        logic [7:0] parity;
        logic [7:0] busy_rd;
        logic [7:0] busy_wr;
        logic [7:0] ext_rej;
        logic [7:0] nores_rej;
        logic [7:0] preset;
        logic [7:0] done;
        logic [7:0] chan_busy;
    } isp_chan_s;

    // Internal fault pulses and peripheral levels
    typedef struct packed {
        logic rtc;
        logic expo;
        logic ovfl;
        logic divf;
        logic bcd;
        logic illw;
        logic srch_done;
        logic tw_busy;
        logic tw_finish;
        logic tw_repeat;
        logic srch_busy;
    } isp_misc_s;
endpackage

// [logic/isp_pause_timer.sv]
module isp_pause_timer
    import isp_pkg::*;
#(
    parameter int LIMIT = PAUSE_LIMIT_CYC
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic run,
    output logic expired
);
    logic [31:0] cnt_r;

    // Cycle counter, restarts whenever the pause is not running
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 32'h0;
        end else if (!run) begin
            cnt_r <= 32'h0;
        end else if (cnt_r < 32'(LIMIT)) begin
            cnt_r <= cnt_r + 32'h1;
        end
    end

    assign expired = run && (cnt_r >= 32'(LIMIT - 1));
endmodule

// [logic/isp_ctrl.sv]
// Contract
// - Sense interrupt: P+1 if masked line active
// - Bits 0-7 channels, 8-11 internal sources
// - Sensed internal faults clear automatically
// - Sense status: P+1 if selected line active
// - Status bit meanings, faults ignore channel
// - Channel interrupt on completion or end record
// - Copy status low, mask high, go P+1
// - Pause holds P while condition, max 40ms
// - Timeout P+1, condition gone P+2
// - Enabled interrupt ends pause, saves own address
// - Pause bits 8-10 decide without pausing
// - Absent bit 9/10 clears typewriter flags
// - Pause bits: channel, typewriter, search busy
// - Priority pause inhibits real-time clock
// - One instruction runs after enable first
// - Disable holds until enable; sensing still works
// - Clear interrupt clears faults, pulses peripherals
// - Set mask ORs; absent channels stay zero
// - Clear mask zeroes selected bits only
// - Lockout blocks busy channel interrupts
//
// Added by the designer: the APB register port and the placing of the registers.
module isp_ctrl
    import isp_pkg::*;
#(
    parameter logic [7:0] CHAN_PRESENT = CHAN_PRESENT_DEF,
    parameter int PAUSE_CYC = PAUSE_LIMIT_CYC
) (
    // APB slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Channel and peripheral conditions
    input wire isp_chan_s chan,
    input wire isp_misc_s misc,
    // Instruction sequencer
    input wire logic instr_done,
    // Outputs to the processor and peripherals
    output logic int_req,
    output logic [7:0] int_clear,
    output logic rtc_inhibit,
    output logic tw_finish_clr,
    output logic tw_repeat_clr
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {ST_IDLE, ST_PAUSE} isp_state_e;
    isp_state_e state_r;
    logic [11:0] mask_r;
    logic [7:0] lock_r;
    logic [7:0] chint_r;
    logic [3:0] fault_r; // rtc, expo/bcd, ovfl/div, search done
    logic [4:0] stat_fault_r; // expo, ovfl, divf, bcd, illw
    logic enabled_r;
    logic [1:0] arm_r;
    logic prio_r;
    logic [11:0] pmask_r;
    isp_step_e step_r;
    logic [23:0] acc_r;
    logic [7:0] clr_r;
    logic tw_fin_clr_r, tw_rep_clr_r;

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    logic wr_en, rd_ok, cmd_wr;
    logic [2:0] ch;
    logic [11:0] x;
    isp_op_e op;
    assign pready = 1'b1;
    assign wr_en = psel && penable && pwrite;
    assign cmd_wr = wr_en && paddr == OFS_CMD && state_r == ST_IDLE;
    assign ch = pwdata[14:12];
    assign x = pwdata[11:0];
    assign rd_ok = paddr == OFS_CMD || paddr == OFS_RESULT || paddr == OFS_MASK
        || paddr == OFS_STATE || paddr == OFS_FAULT;
    assign pslverr = psel && penable && !rd_ok;

    // Command word: bits 19:16 operation, 14:12 channel, 11:0 mask
    assign op = isp_op_e'(pwdata[19:16]);

    // ----------------------------------------------------------------
    // Condition vectors
    // ----------------------------------------------------------------
    logic [7:0] ext_live;
    logic [11:0] int_vec, stat_vec, pause_vec;
    logic [7:0] sel_ch;
    assign sel_ch = 8'h1 << ch;

    // Lockout gates external lines of busy channels
    assign ext_live = (chan.ext_int & ~(lock_r & chan.chan_busy)) | chint_r;
    // Interrupt sensing layout, internal bits ignore channel
    assign int_vec = {fault_r, ext_live};

    function automatic logic pick(input logic [7:0] v, input logic [2:0] c);
        pick = v[c];
    endfunction

    // Internal status layout, bits 5 and 8-11 channel-free
    assign stat_vec = {stat_fault_r[1], stat_fault_r[2], stat_fault_r[3], stat_fault_r[4],
        pick(chint_r, ch), pick(chan.preset, ch), stat_fault_r[0],
        pick(chan.nores_rej, ch), pick(chan.ext_rej, ch), pick(chan.busy_wr, ch),
        pick(chan.busy_rd, ch), pick(chan.parity, ch)};
    // Pause sensing layout
    assign pause_vec = {misc.srch_busy, !misc.tw_repeat, !misc.tw_finish, misc.tw_busy,
        chan.chan_busy};

    logic int_hit, stat_hit, pause_hit, imm_hit;
    logic [11:0] pm;
    assign pm = (state_r == ST_PAUSE) ? pmask_r : x;
    assign int_hit = |(int_vec & x);
    assign stat_hit = |(stat_vec & x);
    assign pause_hit = |(pause_vec & pm & 12'h8ff);
    assign imm_hit = |(pause_vec & pm & 12'h700);

    // Interrupt request gated by enable and mask
    logic any_int;
    assign any_int = |(int_vec & mask_r);
    assign int_req = enabled_r && arm_r == 2'd0 && any_int;

    // ----------------------------------------------------------------
    // Pause timer
    // ----------------------------------------------------------------
    logic expired;
    isp_pause_timer #(.LIMIT(PAUSE_CYC)) u_timer (
        .pclk(pclk),
        .presetn(presetn),
        .run(state_r == ST_PAUSE),
        .expired(expired)
    );

    // ----------------------------------------------------------------
    // Operation sequencing
    // ----------------------------------------------------------------
    // Pause state and step outcome
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_IDLE;
            step_r <= STEP_NONE;
            prio_r <= 1'b0;
            pmask_r <= 12'h000;
        end else if (state_r == ST_PAUSE) begin
            if (int_req) begin
                state_r <= ST_IDLE;
                step_r <= STEP_INT;
            end else if (!pause_hit) begin
                state_r <= ST_IDLE;
                step_r <= STEP_P2;
            end else if (expired) begin
                state_r <= ST_IDLE;
                step_r <= STEP_P1;
            end
        end else if (cmd_wr) begin
            case (op)
                OP_SENSE_INT: step_r <= int_hit ? STEP_P1 : STEP_P2;
                OP_SENSE_STATUS: step_r <= stat_hit ? STEP_P1 : STEP_P2;
                OP_COPY_STATUS: step_r <= STEP_P1;
                OP_PAUSE, OP_PRIO_PAUSE: begin
                    pmask_r <= x;
                    prio_r <= op == OP_PRIO_PAUSE;
                    if (|(x & 12'h700)) begin
                        step_r <= imm_hit ? STEP_P1 : STEP_P2;
                    end else if (pause_hit) begin
                        state_r <= ST_PAUSE;
                        step_r <= STEP_NONE;
                    end else begin
                        step_r <= STEP_P2;
                    end
                end
                default: step_r <= STEP_P1;
            endcase
        end
    end

    assign rtc_inhibit = state_r == ST_PAUSE && prio_r;

    // Copy status into accumulator image
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_r <= 24'h0;
        end else if (cmd_wr && op == OP_COPY_STATUS) begin
            acc_r <= {mask_r, stat_vec};
        end
    end

    // Interrupt enable with one-instruction delay
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enabled_r <= 1'b0;
            arm_r <= 2'd0;
        end else if (cmd_wr && op == OP_ENABLE) begin
            enabled_r <= 1'b1;
            arm_r <= 2'd2;
        end else if (cmd_wr && op == OP_DISABLE) begin
            enabled_r <= 1'b0;
        end else if (instr_done && arm_r != 2'd0) begin
            arm_r <= arm_r - 2'd1;
        end
    end

    // Interrupt mask register, absent channels never set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_r <= MASK_RST;
        end else if (cmd_wr && op == OP_SET_MASK) begin
            mask_r <= mask_r | (x & {4'hf, CHAN_PRESENT});
        end else if (cmd_wr && op == OP_CLR_MASK) begin
            mask_r <= mask_r & ~x;
        end
    end

    // Channel lockout, lifted when the channel goes idle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_r <= 8'h00;
        end else if (cmd_wr && op == OP_LOCKOUT) begin
            lock_r <= x[7:0] & chan.chan_busy;
        end else begin
            lock_r <= lock_r & chan.chan_busy;
        end
    end

    // Channel interrupt status; new completion wins over clear
    logic [7:0] chint_clr;
    assign chint_clr = (cmd_wr && op == OP_CLEAR_INT) ? x[7:0] : 8'h00;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chint_r <= 8'h00;
        end else begin
            chint_r <= (chint_r & ~chint_clr) | chan.done;
        end
    end

    // Internal faults; sensing drops them, clear interrupt drops only fault_r, set wins
    logic [3:0] f_clr;
    logic [4:0] s_clr;
    always_comb begin
        f_clr = 4'h0;
        s_clr = 5'h0;
        if (cmd_wr && op == OP_SENSE_INT) begin
            f_clr = x[11:8];
        end
        if (cmd_wr && op == OP_CLEAR_INT) begin
            f_clr = x[11:8];
        end
        if (cmd_wr && op == OP_SENSE_STATUS) begin
            s_clr = {x[8], x[9], x[10], x[11], x[5]};
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_r <= 4'h0;
            stat_fault_r <= 5'h0;
        end else begin
            fault_r <= (fault_r & ~f_clr) | {misc.srch_done, misc.ovfl | misc.divf,
                misc.expo | misc.bcd, misc.rtc};
            stat_fault_r <= (stat_fault_r & ~s_clr) | {misc.expo, misc.ovfl, misc.divf,
                misc.bcd, misc.illw};
        end
    end

    // Peripheral clear and typewriter flag clear pulses
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clr_r <= 8'h00;
            tw_fin_clr_r <= 1'b0;
            tw_rep_clr_r <= 1'b0;
        end else begin
            clr_r <= (cmd_wr && op == OP_CLEAR_INT) ? x[7:0] : 8'h00;
            tw_fin_clr_r <= cmd_wr && (op == OP_PAUSE || op == OP_PRIO_PAUSE)
                && x[9] && misc.tw_finish;
            tw_rep_clr_r <= cmd_wr && (op == OP_PAUSE || op == OP_PRIO_PAUSE)
                && x[10] && misc.tw_repeat;
        end
    end
    assign int_clear = clr_r;
    assign tw_finish_clr = tw_fin_clr_r;
    assign tw_repeat_clr = tw_rep_clr_r;

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                OFS_RESULT: prdata <= {30'h0, step_r};
                OFS_CMD: prdata <= {8'h0, acc_r};
                OFS_MASK: prdata <= {20'h0, mask_r};
                OFS_STATE: prdata <= {20'h0, lock_r, enabled_r, prio_r,
                    state_r == ST_PAUSE, int_req};
                OFS_FAULT: prdata <= {15'h0, stat_fault_r, chint_r, fault_r};
                default: prdata <= 32'h0;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    chk_req_gate: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_wr && op == OP_DISABLE |=> !int_req) else $error("request after disable");
    chk_enable_delay: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_wr && op == OP_ENABLE |=> !int_req) else $error("early interrupt");
    chk_set_mask: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_wr && op == OP_SET_MASK |=> (mask_r & $past(x)) == ($past(x) & {4'hf, CHAN_PRESENT}))
        else $error("mask set wrong");
    chk_clr_mask: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_wr && op == OP_CLR_MASK |=> (mask_r & $past(x)) == 12'h0)
        else $error("mask clear wrong");
    chk_sense_int: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_wr && op == OP_SENSE_INT |=> step_r == ($past(int_hit) ? STEP_P1 : STEP_P2))
        else $error("sense step wrong");
    chk_pause_drop: assert property (@(posedge pclk) disable iff (!presetn)
        state_r == ST_PAUSE && !int_req && !pause_hit |=> state_r == ST_IDLE && step_r == STEP_P2)
        else $error("pause not ended");
    chk_pause_int: assert property (@(posedge pclk) disable iff (!presetn)
        state_r == ST_PAUSE && int_req |=> step_r == STEP_INT)
        else $error("pause int lost");
    chk_no_pause: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_wr && op == OP_PAUSE && |(x & 12'h700) |=> state_r == ST_IDLE)
        else $error("pause on bits 8-10");
    chk_rtc_hold: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_wr && op == OP_PRIO_PAUSE && !(|(x & 12'h700)) && pause_hit |=> rtc_inhibit)
        else $error("rtc not held");
    chk_lock_busy: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 (lock_r & ~$past(chan.chan_busy)) == 8'h0) else $error("lock kept");
endmodule

// [verif/isp_chan_model.sv]
module isp_chan_model
    import isp_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Line states commanded by the bench
    input wire isp_chan_s want,
    input wire logic [7:0] drop_on_clear,
    // Clear pulses from the controller
    input wire logic [7:0] int_clear,
    // Lines into the controller
    output isp_chan_s chan
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [7:0] ext_r;

    // Interrupt lines latch; only some equipment drops its line on a clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_r <= 8'h00;
        end else begin
            ext_r <= (ext_r | want.ext_int) & ~(int_clear & drop_on_clear);
        end
    end

    // Status levels follow the bench, interrupt lines come from the latch
    always_comb begin
        chan = want;
        chan.ext_int = ext_r;
    end
endmodule

// [verif/test_interrupt_sense_pause_control.sv]
module test_interrupt_sense_pause_control
    import isp_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    // ------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, instr_done, err;
    logic [11:0] paddr, x, mexp;
    logic [31:0] pwdata, prdata, q;
    logic int_req, rtc_inhibit, tw_finish_clr, tw_repeat_clr;
    logic [7:0] int_clear, drop, e;
    logic [7:0] clr_seen = 8'h00;
    logic [1:0] tw_seen = 2'b00;
    logic [2:0] c;
    isp_chan_s want, chan;
    isp_misc_s misc;
    int fails, cmp_count, i, k;
    int seed = 32'h0195a90b;
    int fp[11] = '{10, 9, 6, 8, 7, 4, 5, 9, 8, 7, 6};
    int mb[11] = '{8, 9, 9, 10, 10, 11, 5, 8, 9, 10, 11};

    isp_ctrl #(.CHAN_PRESENT(8'h7f), .PAUSE_CYC(20)) i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .chan(chan), .misc(misc),
        .instr_done(instr_done), .int_req(int_req), .int_clear(int_clear),
        .rtc_inhibit(rtc_inhibit), .tw_finish_clr(tw_finish_clr),
        .tw_repeat_clr(tw_repeat_clr)
    );

    isp_chan_model i_chan (
        .pclk(pclk), .presetn(presetn), .want(want), .drop_on_clear(drop),
        .int_clear(int_clear), .chan(chan)
    );

    // Clock, and capture of the one-cycle output pulses
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        if (int_clear !== 8'h00) clr_seen <= int_clear;
        tw_seen <= tw_seen | {tw_finish_clr, tw_repeat_clr};
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Holds the request until pready is seen high, then releases for a cycle
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a wait that never sees pready
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic cmd(input isp_op_e op, input logic [2:0] ch, input logic [11:0] m);
        logic [31:0] r;
        apb(1'b1, OFS_CMD, {12'h000, op, 1'b0, ch, m}, r);
    endtask

    task automatic sense(input isp_step_e s);
        apb(1'b0, OFS_RESULT, 32'h0, q);
        chk(q, 32'(s), "step");
    endtask

    // Polls the step word; a pause may take the full limit to finish
    task automatic wait_step(input isp_step_e s);
        do begin
            apb(1'b0, OFS_RESULT, 32'h0, q);
        end while (q === 32'h0);
        chk(q, 32'(s), "pause step");
    endtask

    task automatic pulse(input isp_misc_s m);
        misc <= misc | m;
        @(posedge pclk);
        misc <= misc & ~m;
        @(posedge pclk);
    endtask

    task automatic done_pulse();
        instr_done <= 1'b1;
        @(posedge pclk);
        instr_done <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    function automatic logic [11:0] mask_next(input logic [11:0] m, input logic [11:0] v,
                                              input logic set);
        return set ? (m | (v & 12'hf7f)) : (m & ~v);
    endfunction

    // Watchdog well beyond the length of the sequence
    initial begin
        repeat (20000) @(posedge pclk);
        fails++;
        give_verdict();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {psel, penable, pwrite, paddr, pwdata, instr_done} = '0;
        want = '0;
        misc = '0;
        drop = 8'hdf;
        fails = 0;
        cmp_count = 0;
        presetn = 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, OFS_MASK, 32'h0, q);
        chk(q, 32'(MASK_RST), "mask reset");
        apb(1'b0, OFS_STATE, 32'h0, q);
        chk(q, 32'h0, "state reset");
        chk({31'h0, err}, 32'h0, "mapped error");
        apb(1'b0, 12'h014, 32'h0, q);
        chk({31'h0, err}, 32'h1, "unmapped error");
        chk(q, 32'h0, "unmapped data");
        // Random set and clear of mask bits; channel 7 is absent
        mexp = MASK_RST;
        for (i = 0; i < 9; i++) begin
            x = (i == 8) ? 12'hfff : 12'($random(seed));
            cmd(i[0] ? OP_CLR_MASK : OP_SET_MASK, 3'd0, x);
            mexp = mask_next(mexp, x, !i[0]);
            apb(1'b0, OFS_MASK, 32'h0, q);
            chk(q[11:0], mexp, "mask");
        end
        // External lines on random channels, sensed by random masks
        e = 8'($random(seed)) | 8'h20;
        want.ext_int <= e;
        @(posedge pclk);
        want.ext_int <= 8'h00;
        for (i = 0; i < 6; i++) begin
            x = (i == 0) ? 12'h000 : 12'($random(seed)) & 12'h0ff;
            cmd(OP_SENSE_INT, 3'($random(seed)), x);
            sense((x[7:0] & e) != 8'h00 ? STEP_P1 : STEP_P2);
        end
        // Each internal fault is seen once, then has cleared itself
        for (i = 0; i < 11; i++) begin
            pulse(isp_misc_s'(11'h1 << fp[i]));
            cmd(i < 6 ? OP_SENSE_INT : OP_SENSE_STATUS, 3'(i), 12'h1 << mb[i]);
            sense(STEP_P1);
            cmd(i < 6 ? OP_SENSE_INT : OP_SENSE_STATUS, 3'(i), 12'h1 << mb[i]);
            sense(STEP_P2);
        end
        // Channel status levels answer only for the designated channel
        for (k = 0; k < 7; k++) begin
            if (k == 5) continue;
            c = 3'($random(seed));
            want <= isp_chan_s'(72'h1 << ((k == 6 ? 16 : 56 - 8 * k) + c));
            cmd(OP_SENSE_STATUS, c, 12'h1 << k);
            sense(STEP_P1);
            cmd(OP_SENSE_STATUS, c + 3'd1, 12'h1 << k);
            sense(STEP_P2);
        end
        want <= isp_chan_s'(72'h1 << 14);
        @(posedge pclk);
        want <= '0;
        cmd(OP_SENSE_STATUS, 3'd6, 12'h080);
        sense(STEP_P1);
        cmd(OP_COPY_STATUS, 3'd6, 12'h000);
        sense(STEP_P1);
        apb(1'b0, OFS_CMD, 32'h0, q);
        chk({q[23:12], q[7]}, {19'h0, mexp, 1'b1}, "copy image");
        cmd(OP_CLEAR_INT, 3'd0, 12'hfff);
        @(posedge pclk);
        chk(clr_seen, 8'hff, "clear pulses");
        cmd(OP_SENSE_STATUS, 3'd6, 12'h080);
        sense(STEP_P2);
        cmd(OP_SENSE_INT, 3'd0, 12'h0df);
        sense(STEP_P2);
        // Pause on a busy channel: held, then the limit runs out
        want.chan_busy <= 8'h02;
        cmd(OP_PAUSE, 3'd0, 12'h002);
        apb(1'b0, OFS_STATE, 32'h0, q);
        chk(q[1], 1'b1, "pausing");
        sense(STEP_NONE);
        wait_step(STEP_P1);
        cmd(OP_PRIO_PAUSE, 3'd0, 12'h002);
        chk(rtc_inhibit, 1'b1, "clock held");
        want.chan_busy <= 8'h00;
        wait_step(STEP_P2);
        chk(rtc_inhibit, 1'b0, "clock free");
        // Typewriter bits decide at once without pausing
        misc.tw_busy <= 1'b1;
        cmd(OP_PAUSE, 3'd0, 12'h100);
        sense(STEP_P1);
        misc <= isp_misc_s'(11'h004);
        cmd(OP_PAUSE, 3'd0, 12'h200);
        sense(STEP_P2);
        chk(tw_seen, 2'b10, "finish flag clear");
        cmd(OP_PAUSE, 3'd0, 12'h400);
        sense(STEP_P1);
        misc <= isp_misc_s'(11'h006);
        cmd(OP_PAUSE, 3'd0, 12'h400);
        sense(STEP_P2);
        chk(tw_seen, 2'b11, "repeat flag clear");
        // Enable delay, lockout, disable and interrupt during a pause
        misc <= '0;
        cmd(OP_CLR_MASK, 3'd0, 12'hfff);
        cmd(OP_SET_MASK, 3'd0, 12'h020);
        chk(int_req, 1'b0, "request disabled");
        cmd(OP_ENABLE, 3'd0, 12'h000);
        chk(int_req, 1'b0, "request after enable");
        done_pulse();
        chk(int_req, 1'b0, "request one instr");
        done_pulse();
        chk(int_req, 1'b1, "request enabled");
        want.chan_busy <= 8'h20;
        cmd(OP_LOCKOUT, 3'd0, 12'h020);
        chk(int_req, 1'b0, "request locked");
        want.chan_busy <= 8'h00;
        repeat (2) @(posedge pclk);
        chk(int_req, 1'b1, "request unlocked");
        cmd(OP_DISABLE, 3'd0, 12'h000);
        chk(int_req, 1'b0, "request off");
        cmd(OP_SENSE_INT, 3'd0, 12'h020);
        sense(STEP_P1);
        drop <= 8'hff;
        cmd(OP_CLEAR_INT, 3'd0, 12'h020);
        cmd(OP_ENABLE, 3'd0, 12'h000);
        done_pulse();
        done_pulse();
        want.chan_busy <= 8'h02;
        cmd(OP_PAUSE, 3'd0, 12'h002);
        want.ext_int <= 8'h20;
        @(posedge pclk);
        want.ext_int <= 8'h00;
        wait_step(STEP_INT);
        give_verdict();
    end
endmodule
